// >>> hw/apr_alert_router.v
// routing of alert conditions onto the first, shared alert pin, with wishbone registers
`timescale 1ns/10ps
`include "apr_regs.vh"

// Overview of operation
// (RULE1) route bits 14, 13 and 12 gate the overvoltage alerts of channels 2, 3 and 4 to the pin.
// (RULE2) route bits 11 to 8 gate the undervoltage alerts of channels 1 to 4 onto the pin.
// (RULE3) route bits 7 to 4 gate the overpower alerts of channels 1 to 4 onto the pin.
// (RULE4) route bit 3 gates any channel's accumulator overflow or fullness alert onto the pin.
// (RULE5) route bit 2 gates the accumulation count overflow or fullness alert onto the pin.
// (RULE6) route bit 1 makes the pin assert for 5 us at the end of every conversion cycle.
// (RULE7) the conversion-complete pulse appears only while the pin is in its alert function.
// (RULE8) while the pin works as an alert output its slow-mode input is ignored.
// (RULE9) route bit 0 is unimplemented, reads zero and ignores writes.
// (RULE10) route bit 15 gates the channel 1 overvoltage alert onto the pin.
// (RULE11) the host enables alerts globally first and disables them around limit changes.
// (RULE12) the pin asserts while any tripped condition has its route bit set (a plain OR); here also gated by global enable and the alert function.
module apr_alert_router #(
  parameter PULSE_NS = `APR_PULSE_NS,
  parameter CLK_MHZ = `APR_CLK_MHZ
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [9:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [3:0] chan_overvolt_i,
  input wire [3:0] chan_undervolt_i,
  input wire [3:0] chan_overpower_i,
  input wire accum_full_i,
  input wire accum_tally_full_i,
  input wire conv_done_i,
  input wire shared_slow_alert_pin_i,
  output reg shared_slow_alert_pin_o,
  output reg shared_slow_alert_pin_oe_o,
  output reg slow_mode_o,
  output reg irq_o
);

  // ****************************************************************
  // constants
  // ****************************************************************
  localparam integer PULSE_CYC_INT = (PULSE_NS * CLK_MHZ) / 1000;
  localparam integer PULSE_CYC = (PULSE_CYC_INT < 1) ? 1 : PULSE_CYC_INT;
  localparam [7:0] PULSE_LEN = PULSE_CYC[7:0];

  // ****************************************************************
  // registers
  // ****************************************************************
  reg [23:0] route_r;
  reg [1:0] ctrl_r;
  reg [1:0] irq_stat_r;
  reg [1:0] irq_mask_r;
  reg [1:0] slow_sync_r;
  reg conv_prev_r;
  reg alert_prev_r;
  reg [31:0] rd_nxt;
  reg [13:0] trip_r;
  wire cc_pulse;
  wire conv_rise;
  wire alert_fn;
  wire global_en;
  wire cond_alert;
  wire pin_alert;
  wire wb_req;
  wire wr_en;
  wire [13:0] trip_now;
  wire [31:0] route_wr;
  wire hit_route;
  wire hit_trip;
  wire hit_ctrl;
  wire hit_stat;
  wire hit_mask;
  wire [1:0] stat_clr;
  wire [1:0] stat_set;

  // merge a 32-bit write through byte enables
  function [31:0] apr_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] sel;
    integer k;
    begin
      apr_merge = old_v;
      for (k = 0; k < 4; k = k + 1)
      begin
        if (sel[k])
        begin
          apr_merge[k*8 +: 8] = new_v[k*8 +: 8];
        end
      end
    end
  endfunction

  // one address compare function used by every register select, one comparator per call
  function apr_hit;
    input [9:0] adr;
    input [9:0] target;
    begin
      apr_hit = (adr == target);
    end
  endfunction

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en = wb_req & wb_we_i & ce_i;
  assign alert_fn = ctrl_r[`APR_CTRL_ALERT_FN_BIT];
  assign global_en = ctrl_r[`APR_CTRL_GLOBAL_EN_BIT];

  // ****************************************************************
  // register decode
  // ****************************************************************
  assign hit_route = apr_hit(wb_adr_i, `APR_ROUTE_ADDR);
  assign hit_trip = apr_hit(wb_adr_i, `APR_TRIP_ADDR);
  assign hit_ctrl = apr_hit(wb_adr_i, `APR_CTRL_ADDR);
  assign hit_stat = apr_hit(wb_adr_i, `APR_IRQ_STAT_ADDR);
  assign hit_mask = apr_hit(wb_adr_i, `APR_IRQ_MASK_ADDR);

  // the route word is merged lane by lane; the upper byte is outside this block
  assign route_wr = apr_merge({8'h00, route_r}, wb_dat_i, wb_sel_i);
  // control, mask and status live in byte lane 0 only
  assign stat_clr = (wr_en & hit_stat & wb_sel_i[0]) ? wb_dat_i[1:0] : 2'h0;
  assign stat_set = {conv_rise, pin_alert & ~alert_prev_r};

  // ****************************************************************
  // alert routing
  // ****************************************************************
  // trip inputs are registered to the clock domain; monitor logic shares clk_i
  assign trip_now = {chan_overvolt_i, chan_undervolt_i, chan_overpower_i,
    accum_full_i, accum_tally_full_i};

  assign cond_alert =
    (route_r[`APR_OV1_BIT] & trip_r[13]) | // RULE10
    (|(route_r[`APR_OV_HI:`APR_OV_LO] & trip_r[12:10])) | // RULE1
    (|(route_r[`APR_UV_HI:`APR_UV_LO] & trip_r[9:6])) | // RULE2
    (|(route_r[`APR_OP_HI:`APR_OP_LO] & trip_r[5:2])) | // RULE3
    (route_r[`APR_ACC_BIT] & trip_r[1]) | // RULE4
    (route_r[`APR_TALLY_BIT] & trip_r[0]); // RULE5

  // global enable stands in for the host's alert-enable register
  assign pin_alert = alert_fn & ((global_en & cond_alert) | cc_pulse); // RULE12 RULE11

  // a held-high completion line counts once, on its rising edge
  assign conv_rise = conv_done_i & ~conv_prev_r;

  // ****************************************************************
  // conversion-complete pulse
  // ****************************************************************

  apr_pulse_gen #(
    .CNT_W(8),
    .LEN(PULSE_LEN)
  ) u_pulse (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .trig_i(conv_rise & route_r[`APR_CC_BIT] & alert_fn), // RULE6 RULE7
    .pulse_o(cc_pulse)
  );

  // ****************************************************************
  // trip sampling and edge history
  // ****************************************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      trip_r <= 14'h0000;
      conv_prev_r <= 1'b0;
      alert_prev_r <= 1'b0;
    end
    else if (ce_i)
    begin
      trip_r <= trip_now;
      conv_prev_r <= conv_done_i;
      alert_prev_r <= pin_alert;
    end
  end

  // ****************************************************************
  // slow-mode input synchroniser
  // ****************************************************************
  // the pin is asynchronous; only the second stage is read by logic
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      slow_sync_r <= 2'h0;
    end
    else if (ce_i)
    begin
      slow_sync_r <= {slow_sync_r[0], shared_slow_alert_pin_i};
    end
  end

  // ****************************************************************
  // pin outputs
  // ****************************************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      shared_slow_alert_pin_o <= 1'b0;
      shared_slow_alert_pin_oe_o <= 1'b0;
      slow_mode_o <= 1'b0;
    end
    else if (ce_i)
    begin
      // active-high alert driven only in alert function
      shared_slow_alert_pin_o <= pin_alert;
      shared_slow_alert_pin_oe_o <= alert_fn;
      // slow input only honoured while the pin is an input
      slow_mode_o <= slow_sync_r[1] & ~alert_fn; // RULE8
    end
  end

  // ****************************************************************
  // wishbone slave
  // ****************************************************************
  always @*
  begin
    rd_nxt = 32'h00000000;
    if (hit_route)
    begin
      rd_nxt = {8'h00, route_r & `APR_ROUTE_MASK}; // RULE9
    end
    else if (hit_trip)
    begin
      rd_nxt = {18'h0, trip_r};
    end
    else if (hit_ctrl)
    begin
      rd_nxt = {30'h0, ctrl_r};
    end
    else if (hit_stat)
    begin
      rd_nxt = {30'h0, irq_stat_r};
    end
    else if (hit_mask)
    begin
      rd_nxt = {30'h0, irq_mask_r};
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else if (ce_i)
    begin
      // ack is a one-cycle pulse; the ack term in wb_req blocks a double take
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_nxt : 32'h00000000;
    end
  end

  // ****************************************************************
  // register bank
  // ****************************************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      route_r <= `APR_ROUTE_RST;
    end
    else if (ce_i)
    begin
      if (wr_en && hit_route)
      begin
        // bits 23:16 belong to other alert kinds; bit 0 stays zero
        route_r <= route_wr[23:0] & `APR_ROUTE_MASK; // RULE9
      end
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= `APR_CTRL_RST;
    end
    else if (ce_i)
    begin
      if (wr_en && hit_ctrl && wb_sel_i[0])
      begin
        ctrl_r <= wb_dat_i[1:0];
      end
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_mask_r <= `APR_IRQ_RST;
    end
    else if (ce_i)
    begin
      if (wr_en && hit_mask && wb_sel_i[0])
      begin
        irq_mask_r <= wb_dat_i[1:0];
      end
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  // set wins over a write-one clear in the same cycle, so no event is lost
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_stat_r <= `APR_IRQ_RST;
    end
    else if (ce_i)
    begin
      irq_stat_r <= (irq_stat_r & ~stat_clr) | stat_set;
    end
  end

  // the level trails status by one cycle so that it comes from a flop
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_o <= 1'b0;
    end
    else if (ce_i)
    begin
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

endmodule

// >>> hw/apr_pulse_gen.v
// fixed-width pulse stretcher for the conversion-complete alert
`timescale 1ns/10ps
module apr_pulse_gen #(
  parameter CNT_W = 8,
  parameter [CNT_W-1:0] LEN = 8'h7D
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire trig_i,
  output reg pulse_o
);

  reg [CNT_W-1:0] cnt_r;

  // a new trigger while a pulse is running restarts the full width
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_r <= {CNT_W{1'b0}};
      pulse_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (trig_i)
      begin
        cnt_r <= LEN - {{(CNT_W-1){1'b0}}, 1'b1};
        pulse_o <= 1'b1;
      end
      else if (cnt_r != {CNT_W{1'b0}})
      begin
        cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
      end
      else
      begin
        pulse_o <= 1'b0;
      end
    end
  end

endmodule

// >>> hw/apr_regs.vh
// register offsets, field positions, reset values and timing counts of the alert pin router
`ifndef APR_REGS_VH
`define APR_REGS_VH
// byte addresses (index times four)
`define APR_ROUTE_IDX 8'h27
`define APR_ROUTE_ADDR 10'h09C
`define APR_TRIP_ADDR 10'h000
`define APR_CTRL_ADDR 10'h004
`define APR_IRQ_STAT_ADDR 10'h008
`define APR_IRQ_MASK_ADDR 10'h00C
// route register fields
`define APR_OV1_BIT 15
`define APR_OV_HI 14
`define APR_OV_LO 12
`define APR_UV_HI 11
`define APR_UV_LO 8
`define APR_OP_HI 7
`define APR_OP_LO 4
`define APR_ACC_BIT 3
`define APR_TALLY_BIT 2
`define APR_CC_BIT 1
`define APR_ROUTE_MASK 24'h00FFFE
`define APR_ROUTE_RST 24'h000000
// control register fields
`define APR_CTRL_ALERT_FN_BIT 0
`define APR_CTRL_GLOBAL_EN_BIT 1
`define APR_CTRL_RST 2'h0
// interrupt status fields
`define APR_IRQ_ALERT_BIT 0
`define APR_IRQ_CONV_BIT 1
`define APR_IRQ_RST 2'h0
// conversion-complete pulse
`define APR_PULSE_NS 5000
`define APR_CLK_MHZ 25
`endif

// >>> testbench/apr_host_model.sv
// host that times how long the shared wire stays high
`timescale 1ns/10ps
module apr_host_model (
  input wire clk_i,
  input wire alert_i,
  output int width_o
);
  int run = 0;
  // the host samples once a cycle, so width is in whole clocks
  always @(posedge clk_i)
    if (alert_i === 1'h1)
      run <= run + 1;
    else if (run != 0)
    begin
      width_o <= run;
      run <= 0;
    end
endmodule

// >>> testbench/apr_monitor.sv
// port assertions for the alert pin router
`timescale 1ns/10ps
`include "apr_regs.vh"
module apr_monitor (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [9:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire shared_slow_alert_pin_o,
  input wire shared_slow_alert_pin_oe_o,
  input wire slow_mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_take_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data outside ack");
  route_bit0_a: assert property (wb_ack_o &&
    $past(wb_adr_i) == `APR_ROUTE_ADDR |-> !wb_dat_o[0]) else $error("bit 0 set");
  route_top_a: assert property (wb_ack_o &&
    $past(wb_adr_i) == `APR_ROUTE_ADDR |-> wb_dat_o[31:16] == 16'h0) else $error("top set");
  pin_fn_a: assert property (shared_slow_alert_pin_o |-> shared_slow_alert_pin_oe_o)
    else $error("alert outside alert function");
  slow_off_a: assert property (shared_slow_alert_pin_oe_o |-> !slow_mode_o)
    else $error("slow mode in alert function");
  fn_cause_a: assert property ($changed(shared_slow_alert_pin_oe_o) |-> $past(wb_ack_o))
    else $error("function changed without write");
endmodule

// >>> testbench/test_alert_pin_one_routing.sv
// self-checking bench for the alert pin router
`timescale 1ns/10ps
`include "apr_regs.vh"
module test_alert_pin_one_routing;
  logic clk = 1'h0, rst = 1'h1, cyc = 1'h0, we = 1'h0, conv = 1'h0, slow = 1'h0;
  logic [9:0] adr = 10'h0;
  logic [31:0] dat = 32'h0, rdat;
  logic [13:0] trp = 14'h0;
  wire [31:0] dout;
  wire ack, pin, oe, slm, irq, lvl;
  int fails = 0, cmp_count = 0, width, route_m;
  // shared wire: our level while enabled, else the host's slow-mode level
  assign lvl = oe ? pin : slow;
  initial forever #20 clk = ~clk;
  apr_alert_router i_dut (.clk_i(clk), .rst_i(rst), .ce_i(1'h1), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(dout), .wb_ack_o(ack), .chan_overvolt_i(trp[13:10]),
    .chan_undervolt_i(trp[9:6]), .chan_overpower_i(trp[5:2]), .accum_full_i(trp[1]),
    .accum_tally_full_i(trp[0]), .conv_done_i(conv), .shared_slow_alert_pin_i(lvl),
    .shared_slow_alert_pin_o(pin), .shared_slow_alert_pin_oe_o(oe), .slow_mode_o(slm),
    .irq_o(irq));
  apr_host_model i_host (.clk_i(clk), .alert_i(lvl), .width_o(width));
  task automatic end_of_test;
    if (fails == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, s);
      fails++;
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'h1 && n < 20);
    if (ack !== 1'h1)
    begin
      fails++;
      end_of_test;
    end
    rdat = dout;
    cyc <= 1'h0;
  endtask
  task automatic trip(input logic [13:0] t);
    @(posedge clk);
    trp <= t;
    repeat (3) @(posedge clk);
    chk("pin", 32'(|(route_m[15:2] & t)), 32'(pin));
  endtask
  task automatic pulse;
    @(posedge clk);
    conv <= 1'h1;
    @(posedge clk);
    conv <= 1'h0;
    repeat (140) @(posedge clk);
  endtask
  initial
  begin
    void'($urandom(66));
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    bus(1'h0, `APR_ROUTE_ADDR, 32'h0);
    chk("route reset", `APR_ROUTE_RST, rdat);
    bus(1'h0, 10'h3F0, 32'h0);
    chk("unmapped", 32'h0, rdat);
    // global enable goes in before any routing
    bus(1'h1, `APR_CTRL_ADDR, 32'h3);
    for (int b = 0; b < 34; b++)
    begin
      route_m = (b < 14) ? 32'h4 << b : $urandom & 32'hFFFFFF;
      bus(1'h1, `APR_ROUTE_ADDR, route_m);
      bus(1'h0, `APR_ROUTE_ADDR, 32'h0);
      chk("route", route_m & `APR_ROUTE_MASK, rdat);
      trip((b < 14) ? 14'h3FFF ^ (14'h1 << b) : 14'($urandom));
      trip(14'h1 << b);
    end
    trip(14'h0);
    bus(1'h1, `APR_IRQ_MASK_ADDR, 32'h2);
    bus(1'h1, `APR_ROUTE_ADDR, 32'h2);
    pulse;
    chk("width", 32'h7D, width);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'h1, `APR_IRQ_STAT_ADDR, 32'h2);
    repeat (3) @(posedge clk);
    chk("irq clear", 32'h0, {31'h0, irq});
    bus(1'h1, `APR_CTRL_ADDR, 32'h2);
    slow <= 1'h1;
    pulse;
    chk("pin off", 32'h0, {31'h0, pin | oe});
    chk("slow", 32'h1, {31'h0, slm});
    bus(1'h1, `APR_CTRL_ADDR, 32'h3);
    repeat (3) @(posedge clk);
    chk("slow off", 32'h0, {31'h0, slm});
    // drive the shared wire high from the alert side: slow mode must stay off
    route_m = 32'h8000;
    bus(1'h1, `APR_ROUTE_ADDR, route_m);
    trip(14'h2000);
    repeat (4) @(posedge clk);
    chk("slow held", 32'h0, {31'h0, slm});
    end_of_test;
  end
endmodule
bind apr_alert_router apr_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .shared_slow_alert_pin_o(shared_slow_alert_pin_o),
  .shared_slow_alert_pin_oe_o(shared_slow_alert_pin_oe_o), .slow_mode_o(slow_mode_o));
